// file: include/ipp_params.svh
// constants for the interrupt priority and polarity unit
// Functional notes
// - edge_select bit 2 picks port B edge
// - edge_select bit 1 picks port A edge
// - edge_select bit 0 picks nonmaskable edge
// - bits 7:5 unused, 4:3 timer owned
// - three registers form 24-bit eight-level map
// - bits 2:0 level 1, 23:21 level 8
// - nonmaskable level 0, only trap above
// - fixed source codes and clear codes
// - code 110 at level 3 ranks port A
// - edge_select at 01h, resets to zero
// - map registers 02h..04h, reset zero
// - masked source stays pending, not granted
// - grant highest pending at instruction end
// - clear code discards that source's pending
// - each source has a fixed vector address
`ifndef IPP_PARAMS_SVH
`define IPP_PARAMS_SVH
`define IPP_ADDR_MASK 4'h0
`define IPP_ADDR_EDGE 4'h1
`define IPP_ADDR_MAPH 4'h2
`define IPP_ADDR_MAPM 4'h3
`define IPP_ADDR_MAPL 4'h4
`define IPP_ADDR_STAT 4'h5
`define IPP_ADDR_IEN 4'h6
`define IPP_ADDR_ICLR 4'h7
`define IPP_ADDR_GRANT 4'h8
`define IPP_BIT_NMI 0
`define IPP_BIT_PA 1
`define IPP_BIT_PB 2
`define IPP_EDGE_WMASK 8'h1f
`define IPP_MASK_WMASK 8'hf6
`define IPP_RST8 8'h00
`define IPP_CODE_T0 3'h1
`define IPP_CODE_T1 3'h2
`define IPP_CODE_SPI 3'h4
`define IPP_CODE_I2C 3'h5
`define IPP_CODE_PA 3'h6
`define IPP_CODE_PB 3'h7
`define IPP_CLR_NMI 4'h8
`define IPP_VEC_T0 6'h06
`define IPP_VEC_T1 6'h09
`define IPP_VEC_SPI 6'h0f
`define IPP_VEC_I2C 6'h12
`define IPP_VEC_PA 6'h15
`define IPP_VEC_PB 6'h18
`define IPP_VEC_NMI 6'h1b
`define IPP_VEC_TRAP 6'h1e
`define IPP_LVL_TRAP 4'hf
`define IPP_LVL_NMI 4'h0
`define IPP_LVL_NONE 4'he
`endif

// file: include/ipp_pkg.sv
// types for the interrupt priority and polarity unit
package ipp_pkg;
	typedef enum logic [1:0] {IPP_IDLE, IPP_RD, IPP_WR} ipp_bus_t;
	typedef logic [7:0] ipp_byte_t;
endpackage

// file: hdl/ipp_edge_catch.sv
// one interrupt line: edge detect with sticky pending flag
`timescale 1ns/1ps
`default_nettype none
module ipp_edge_catch (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// line and control
	input wire logic i_line,
	input wire logic i_falling,
	input wire logic i_clear,
	// pending out
	output logic o_pending,
	output logic o_event
);
	logic prev_r;
	logic hit;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			// track the pin in reset: no false edge on release
			prev_r <= i_line;
		end else begin
			prev_r <= i_line;
		end
	end

	// selected-polarity transition, sampled once per clock
	assign hit = i_falling ? (prev_r & ~i_line) : (~prev_r & i_line);
	assign o_event = hit & ~i_srst;

	// set wins over clear
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_pending <= 1'b0;
		end else if (hit) begin
			o_pending <= 1'b1;
		end else if (i_clear) begin
			o_pending <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: hdl/ipp_level_pick.sv
// finds the highest map level holding a given source code
`timescale 1ns/1ps
`default_nettype none
`include "ipp_params.svh"
module ipp_level_pick (
	// map and code
	input wire logic [23:0] i_map,
	input wire logic [2:0] i_code,
	// result
	output logic [3:0] o_level
);
	// scan level 8 first and level 1 last, so level 1 wins
	always_comb begin
		o_level = `IPP_LVL_NONE;
		for (int k = 7; k >= 0; k--) begin
			if (i_map[3*k +: 3] == i_code) begin
				o_level = 4'(k + 1);
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/ipp_unit.sv
// interrupt priority, polarity and pending unit with Avalon-MM slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "ipp_params.svh"
module ipp_unit
	import ipp_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_srst,
	// avalon-mm slave
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// interrupt lines: t0, t1, spi, i2c levels are event pulses
	input wire logic i_timer0,
	input wire logic i_timer1,
	input wire logic i_spi,
	input wire logic i_i2c,
	input wire logic i_port_a,
	input wire logic i_port_b,
	input wire logic i_nmi,
	// control unit
	input wire logic i_trap,
	input wire logic i_instr_end,
	input wire logic i_clear_pending_instr,
	input wire logic [3:0] i_clear_code,
	input wire logic [3:0] i_active_level,
	// grant outputs
	output logic o_grant,
	output logic [5:0] o_vector,
	output logic [3:0] o_grant_level,
	output logic [7:0] o_edge_select,
	output logic o_irq
);
	logic [7:0] mask_r;
	logic [7:0] edge_select_r;
	logic [7:0] level_map_high_r;
	logic [7:0] level_map_mid_r;
	logic [7:0] level_map_low_r;
	logic [7:0] stat_r;
	logic [7:0] ien_r;
	logic [7:0] grant_lvl_r;
	logic [23:0] level_map_bits;
	logic [6:0] lines;
	logic [6:0] falling;
	logic [6:0] clr;
	logic [6:0] pend;
	logic [6:0] evt;
	logic [6:0] mbit;
	logic [2:0] codes [6];
	logic [5:0] vecs [7];
	logic [3:0] lvl [6];
	logic [3:0] best_lvl;
	logic [2:0] best_idx;
	logic best_ok;
	logic take_grant;
	logic [6:0] gclr;
	logic [2:0] win_idx;
	logic wr_ok;
	logic rd_ok;
	logic ack_r;
	ipp_bus_t bus_st;

	assign level_map_bits = {level_map_high_r, level_map_mid_r,
		level_map_low_r};
	assign lines = {i_nmi, i_port_b, i_port_a, i_i2c, i_spi, i_timer1,
		i_timer0};
	// index order t0,t1,spi,i2c,pa,pb,nmi
	assign falling = {edge_select_r[`IPP_BIT_NMI],
		edge_select_r[`IPP_BIT_PB], edge_select_r[`IPP_BIT_PA],
		4'h0};
	assign codes[0] = `IPP_CODE_T0;
	assign codes[1] = `IPP_CODE_T1;
	assign codes[2] = `IPP_CODE_SPI;
	assign codes[3] = `IPP_CODE_I2C;
	assign codes[4] = `IPP_CODE_PA;
	assign codes[5] = `IPP_CODE_PB;
	assign vecs[0] = `IPP_VEC_T0;
	assign vecs[1] = `IPP_VEC_T1;
	assign vecs[2] = `IPP_VEC_SPI;
	assign vecs[3] = `IPP_VEC_I2C;
	assign vecs[4] = `IPP_VEC_PA;
	assign vecs[5] = `IPP_VEC_PB;
	assign vecs[6] = `IPP_VEC_NMI;
	// mask bits 1,2,4,5,6,7 map to sources; nmi unmaskable
	assign mbit = {1'b1, mask_r[7:4], mask_r[2:1]};

	// clear-pending codes 1,2,4,5,6,7 and 8
	always_comb begin
		clr = gclr;
		if (i_clear_pending_instr) begin
			for (int k = 0; k < 6; k++) begin
				if (i_clear_code == {1'b0, codes[k]}) begin
					clr[k] = 1'b1;
				end
			end
			if (i_clear_code == `IPP_CLR_NMI) begin
				clr[6] = 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : gen_src
			ipp_edge_catch u_catch (
				.i_clock(i_clock),
				.i_srst(i_srst),
				.i_line(lines[g]),
				.i_falling(falling[g]),
				.i_clear(clr[g]),
				.o_pending(pend[g]),
				.o_event(evt[g])
			);
		end
		for (g = 0; g < 6; g++) begin : gen_lvl
			ipp_level_pick u_pick (
				.i_map(level_map_bits),
				.i_code(codes[g]),
				.o_level(lvl[g])
			);
		end
	endgenerate

	// pick highest-priority enabled pending source
	always_comb begin
		best_ok = 1'b0;
		best_idx = 3'h0;
		best_lvl = `IPP_LVL_NONE;
		for (int k = 0; k < 6; k++) begin
			if (pend[k] && mbit[k] && lvl[k] < best_lvl) begin
				best_ok = 1'b1;
				best_idx = 3'(k);
				best_lvl = lvl[k];
			end
		end
		if (pend[6]) begin
			best_ok = 1'b1;
			best_idx = 3'h6;
			best_lvl = `IPP_LVL_NMI;
		end
	end

	// only pre-empt a routine of lower priority (larger level)
	assign take_grant = i_instr_end & ~i_trap & best_ok &
		(best_lvl < i_active_level);
	assign win_idx = best_idx;

	always_comb begin
		gclr = 7'h00;
		if (take_grant) begin
			gclr[win_idx] = 1'b1;
		end
	end

	// grant outputs registered; trap always wins
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_grant <= 1'b0;
			o_vector <= 6'h00;
			o_grant_level <= `IPP_LVL_NONE;
		end else if (i_trap) begin
			o_grant <= 1'b1;
			o_vector <= `IPP_VEC_TRAP;
			o_grant_level <= `IPP_LVL_TRAP;
		end else if (take_grant) begin
			o_grant <= 1'b1;
			o_vector <= vecs[win_idx];
			o_grant_level <= best_lvl;
		end else begin
			o_grant <= 1'b0;
		end
	end

	// bus: one wait cycle, then ack
	assign wr_ok = i_write & ack_r;
	assign rd_ok = i_read & ack_r;
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			bus_st <= IPP_IDLE;
			ack_r <= 1'b0;
		end else if (ack_r) begin
			bus_st <= IPP_IDLE;
			ack_r <= 1'b0;
		end else begin
			case (bus_st)
				IPP_IDLE: begin
					bus_st <= i_read ? IPP_RD : (i_write ? IPP_WR : IPP_IDLE);
					ack_r <= i_read | i_write;
				end
				default: begin
					bus_st <= IPP_IDLE;
				end
			endcase
		end
	end
	assign o_waitrequest = ~ack_r;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			mask_r <= `IPP_RST8;
			edge_select_r <= `IPP_RST8;
			level_map_high_r <= `IPP_RST8;
			level_map_mid_r <= `IPP_RST8;
			level_map_low_r <= `IPP_RST8;
			ien_r <= `IPP_RST8;
		end else if (wr_ok) begin
			case (i_address)
				`IPP_ADDR_MASK: mask_r <= i_writedata[7:0] & `IPP_MASK_WMASK;
				`IPP_ADDR_EDGE: begin
					edge_select_r <= i_writedata[7:0] & `IPP_EDGE_WMASK;
				end
				`IPP_ADDR_MAPH: level_map_high_r <= i_writedata[7:0];
				`IPP_ADDR_MAPM: level_map_mid_r <= i_writedata[7:0];
				`IPP_ADDR_MAPL: level_map_low_r <= i_writedata[7:0];
				`IPP_ADDR_IEN: ien_r <= {1'b0, i_writedata[6:0]};
				default: begin
				end
			endcase
		end
	end

	// sticky status, set wins over write-one-to-clear
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			stat_r <= `IPP_RST8;
		end else begin
			for (int k = 0; k < 7; k++) begin
				if (evt[k]) begin
					stat_r[k] <= 1'b1;
				end else if (wr_ok && i_address == `IPP_ADDR_ICLR &&
					i_writedata[k]) begin
					stat_r[k] <= 1'b0;
				end
			end
			stat_r[7] <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_irq <= 1'b0;
			o_edge_select <= `IPP_RST8;
			grant_lvl_r <= `IPP_RST8;
		end else begin
			o_irq <= |(stat_r & ien_r);
			o_edge_select <= edge_select_r;
			grant_lvl_r <= {4'h0, best_lvl};
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_readdata <= 32'h0;
		end else if (i_read && !ack_r) begin
			case (i_address)
				`IPP_ADDR_MASK: o_readdata <= {24'h0, mask_r};
				`IPP_ADDR_EDGE: o_readdata <= {24'h0, edge_select_r};
				`IPP_ADDR_MAPH: o_readdata <= {24'h0, level_map_high_r};
				`IPP_ADDR_MAPM: o_readdata <= {24'h0, level_map_mid_r};
				`IPP_ADDR_MAPL: o_readdata <= {24'h0, level_map_low_r};
				`IPP_ADDR_STAT: o_readdata <= {24'h0, stat_r};
				`IPP_ADDR_IEN: o_readdata <= {24'h0, ien_r};
				`IPP_ADDR_GRANT: o_readdata <= {17'h0, pend, grant_lvl_r};
				default: o_readdata <= 32'h0;
			endcase
		end
	end

	// assertions
	sequence rd_edge_s;
		i_read && !ack_r && i_address == `IPP_ADDR_EDGE;
	endsequence

	edge_reset_zero_a: assert property (@(posedge i_clock)
		i_srst |=> edge_select_r == 8'h00 && level_map_low_r == 8'h00)
		else $error("registers not zero after reset");
	edge_reserved_zero_a: assert property (@(posedge i_clock)
		disable iff (i_srst) edge_select_r[7:5] == 3'h0)
		else $error("reserved edge bits set");
	edge_read_back_a: assert property (@(posedge i_clock)
		disable iff (i_srst) rd_edge_s |=> o_readdata[7:0] == edge_select_r)
		else $error("edge register read mismatch");
	nmi_first_a: assert property (@(posedge i_clock)
		disable iff (i_srst) take_grant && pend[6] |-> win_idx == 3'h6)
		else $error("nmi not served first");
	trap_top_a: assert property (@(posedge i_clock)
		disable iff (i_srst) i_trap |=> o_vector == `IPP_VEC_TRAP)
		else $error("trap not top");
	masked_held_a: assert property (@(posedge i_clock)
		disable iff (i_srst) take_grant |-> mbit[win_idx])
		else $error("masked source granted");
	unmapped_never_a: assert property (@(posedge i_clock)
		disable iff (i_srst) take_grant |-> best_lvl != `IPP_LVL_NONE)
		else $error("unmapped source granted");
	grant_clears_a: assert property (@(posedge i_clock)
		disable iff (i_srst) take_grant && !evt[win_idx] |=> !pend[$past(win_idx)])
		else $error("granted pending not cleared");
	clear_code_a: assert property (@(posedge i_clock)
		disable iff (i_srst) i_clear_pending_instr &&
		i_clear_code == `IPP_CLR_NMI && !evt[6] |=> !pend[6])
		else $error("clear code ignored");
	edge_latch_a: assert property (@(posedge i_clock)
		disable iff (i_srst) evt[4] |=> pend[4] && stat_r[4])
		else $error("edge not latched");
endmodule
`default_nettype wire

// file: bench/ipp_peer.sv
// far-side model: interrupt lines and control unit sequencer
`timescale 1ns/1ps
`default_nettype none
module ipp_peer (
	// clock
	input wire logic i_clock,
	// lines: t0,t1,spi,i2c,pa,pb,nmi
	output logic [6:0] o_lines,
	// sequencer strobes
	output logic o_trap,
	output logic o_instr_end,
	output logic o_clear_pending_instr,
	output logic [3:0] o_clear_code,
	output logic [3:0] o_active_level
);
	initial begin
		o_lines = 7'h00;
		o_trap = 1'b0;
		o_instr_end = 1'b0;
		o_clear_pending_instr = 1'b0;
		o_clear_code = 4'h0;
		o_active_level = 4'hf;
	end
	// lines set, then held for four more clocks
	task automatic lines(input logic [6:0] v);
		@(posedge i_clock);
		o_lines <= v;
		repeat (4) @(posedge i_clock);
	endtask
	// level of the routine now running, 15 for the main program
	task automatic level(input logic [3:0] v);
		@(posedge i_clock);
		o_active_level <= v;
	endtask
	// one-cycle strobe: 0 instruction end, 1 trap, 2 clear
	task automatic strobe(input int k, input logic [3:0] code);
		@(posedge i_clock);
		o_instr_end <= (k == 0);
		o_trap <= (k == 1);
		o_clear_pending_instr <= (k == 2);
		o_clear_code <= code;
		@(posedge i_clock);
		o_instr_end <= 1'b0;
		o_trap <= 1'b0;
		o_clear_pending_instr <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: bench/interrupt_priority_polarity_unit_bench.sv
// self-checking bench for the interrupt priority and polarity unit
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_polarity_unit_bench;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	logic [3:0] i_address = 4'h0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [31:0] o_readdata, rd;
	logic o_waitrequest, o_grant, o_irq, tp, ie, cp;
	logic [5:0] o_vector;
	logic [3:0] o_grant_level, cc, al;
	logic [7:0] o_edge_select;
	logic [6:0] ln;
	logic [23:0] map = {3'h0, 3'h0, 3'h0, 3'h4, 3'h7, 3'h6, 3'h2, 3'h1};
	logic [6:0] eln [3] = '{7'h40, 7'h10, 7'h20};
	logic [5:0] evec [3] = '{6'h1b, 6'h15, 6'h18};
	logic [3:0] elvl [3] = '{4'h0, 4'h3, 4'h4};
	logic [3:0] ccode [7] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	ipp_peer PEER (.i_clock(i_clock), .o_lines(ln), .o_trap(tp),
		.o_instr_end(ie), .o_clear_pending_instr(cp),
		.o_clear_code(cc), .o_active_level(al));
	ipp_unit DUT (.i_clock(i_clock), .i_srst(i_srst),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_timer0(ln[0]),
		.i_timer1(ln[1]), .i_spi(ln[2]), .i_i2c(ln[3]),
		.i_port_a(ln[4]), .i_port_b(ln[5]), .i_nmi(ln[6]), .i_trap(tp),
		.i_instr_end(ie), .i_clear_pending_instr(cp),
		.i_clear_code(cc), .i_active_level(al), .o_grant(o_grant),
		.o_vector(o_vector), .o_grant_level(o_grant_level),
		.o_edge_select(o_edge_select), .o_irq(o_irq));
	always #2 i_clock = ~i_clock;
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// bus cycle held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge i_clock);
		i_address <= a;
		i_write <= w;
		i_read <= !w;
		i_writedata <= {24'h0, d};
		do begin
			@(posedge i_clock);
		end while (o_waitrequest !== 1'b0);
		rd = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, e);
	endtask
	task automatic grant(input logic g, input logic [5:0] v,
		input logic [3:0] l);
		PEER.strobe(0, 4'h0);
		@(negedge i_clock);
		chk({31'h0, o_grant}, {31'h0, g});
		if (g) begin
			chk({26'h0, o_vector}, {26'h0, v});
			chk({28'h0, o_grant_level}, {28'h0, l});
		end
	endtask
	task automatic t_regs();
		for (int a = 0; a < 5; a++) rc(a[3:0], 32'h0);
		rc(4'h9, 32'h0);
		chk({28'h0, o_grant_level}, 32'he);
		wr(4'h1, 8'hff);
		rc(4'h1, 32'h1f);
		chk({24'h0, o_edge_select}, 32'h1f);
		wr(4'h1, 8'h00);
		wr(4'h2, map[23:16]);
		wr(4'h3, map[15:8]);
		wr(4'h4, map[7:0]);
		rc(4'h2, {24'h0, map[23:16]});
		rc(4'h3, {24'h0, map[15:8]});
		rc(4'h4, {24'h0, map[7:0]});
		wr(4'h9, 8'hff);
		rc(4'h9, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_prio();
		wr(4'h0, 8'hf6);
		PEER.level(4'h3);
		PEER.lines(7'h30);
		grant(1'b0, 6'h0, 4'h0);
		PEER.level(4'h4);
		grant(1'b1, 6'h15, 4'h3);
		grant(1'b0, 6'h0, 4'h0);
		PEER.level(4'hf);
		grant(1'b1, 6'h18, 4'h4);
		PEER.lines(7'h08);
		grant(1'b0, 6'h0, 4'h0);
		PEER.strobe(2, 4'h5);
		PEER.lines(7'h00);
		$display("test priority done");
	endtask
	task automatic t_edge();
		for (int k = 0; k < 3; k++) begin
			wr(4'h1, 8'h01 << k);
			wr(4'h7, 8'h7f);
			PEER.lines(eln[k]);
			rc(4'h5, 32'h0);
			PEER.lines(7'h00);
			rc(4'h5, {25'h0, eln[k]});
			grant(1'b1, evec[k], elvl[k]);
		end
		wr(4'h1, 8'h00);
		$display("test edges done");
	endtask
	task automatic t_mask();
		wr(4'h0, 8'h00);
		wr(4'h7, 8'h7f);
		PEER.lines(7'h01);
		grant(1'b0, 6'h0, 4'h0);
		rc(4'h5, 32'h01);
		wr(4'h0, 8'hf6);
		grant(1'b1, 6'h06, 4'h1);
		PEER.lines(7'h00);
		wr(4'h0, 8'h00);
		PEER.lines(7'h7f);
		for (int c = 0; c < 7; c++) PEER.strobe(2, ccode[c]);
		wr(4'h0, 8'hf6);
		grant(1'b0, 6'h0, 4'h0);
		PEER.lines(7'h00);
		$display("test mask done");
	endtask
	task automatic t_irq();
		wr(4'h6, 8'h01);
		wr(4'h7, 8'h7f);
		PEER.lines(7'h01);
		chk({31'h0, o_irq}, 32'h1);
		wr(4'h6, 8'h00);
		repeat (2) @(negedge i_clock);
		chk({31'h0, o_irq}, 32'h0);
		wr(4'h6, 8'h01);
		repeat (2) @(negedge i_clock);
		chk({31'h0, o_irq}, 32'h1);
		wr(4'h7, 8'h01);
		repeat (2) @(negedge i_clock);
		chk({31'h0, o_irq}, 32'h0);
		grant(1'b1, 6'h06, 4'h1);
		PEER.lines(7'h00);
		PEER.strobe(1, 4'h0);
		@(negedge i_clock);
		chk({26'h0, o_vector}, 32'h1e);
		chk({28'h0, o_grant_level}, 32'hf);
		$display("test irq and trap done");
	endtask
	// reset in mid-run with every line held high
	task automatic t_reset();
		wr(4'h1, 8'h07);
		PEER.lines(7'h7f);
		@(posedge i_clock);
		i_srst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_srst <= 1'b0;
		rc(4'h5, 32'h0);
		rc(4'h1, 32'h0);
		rc(4'h8, 32'he);
		chk({28'h0, o_grant_level}, 32'he);
		PEER.lines(7'h00);
		$display("test reset done");
	endtask
	initial begin
		repeat (20) @(posedge i_clock);
		i_srst <= 1'b0;
		t_regs();
		t_prio();
		t_edge();
		t_mask();
		t_irq();
		t_reset();
		conclude();
	end
endmodule
`default_nettype wire
